// *** vtiming_cfg.svh ***
// Register indices, field positions and reset values for the vertical timing block
`ifndef VTIMING_CFG_SVH
`define VTIMING_CFG_SVH

// ----------------------------------------------------------------
// Indexed register numbers
// ----------------------------------------------------------------
`define IDX_VERT_TOTAL      8'h06
`define IDX_HIGH_BITS       8'h07
`define IDX_PRESET_ROW      8'h08
`define IDX_MAX_SCAN        8'h09
`define IDX_VSYNC_START     8'h10
`define IDX_VDISP_END       8'h12
`define IDX_VBLANK_START    8'h15
`define IDX_LINE_CMP        8'h18
`define IDX_START_HI        8'h0C
`define IDX_START_LO        8'h0D
`define IDX_EXT_VTOTAL      8'h30
`define IDX_EXT_VDISP       8'h31
`define IDX_EXT_VSYNC       8'h32
`define IDX_EXT_VBLANK      8'h33

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HB_VSYNC_B9         7
`define HB_VDISP_B9         6
`define HB_VTOTAL_B9        5
`define HB_LCMP_B8          4
`define HB_VBLANK_B8        3
`define HB_VSYNC_B8         2
`define HB_VDISP_B8         1
`define HB_VTOTAL_B8        0
`define MS_LCMP_B9          6
`define MS_VBLANK_B9        5
`define PR_PAN_HI           6
`define PR_PAN_LO           5
`define PR_ROW_HI           4
`define PR_ROW_LO           0
`define PR_WRITE_MASK       8'h7F
`define EXT_NIB_MASK        8'h0F

// ----------------------------------------------------------------
// Reset values and character widths
// ----------------------------------------------------------------
`define REG_RESET           8'h00
`define CHAR_W9             5'h09
`define CHAR_W8             5'h08

`endif

// *** vtiming_pkg.sv ***
// Types shared by the vertical timing block
package vtiming_pkg;
  typedef logic [11:0] vval_t;
  typedef logic [7:0]  byte_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } bus_state_t;
endpackage

// *** vtiming_compose.sv ***
// Composes one vertical timing value from low, standard-high and extended bits
`timescale 1ns/10ps
module vtiming_compose
  import vtiming_pkg::*;
(
  input  wire logic [7:0]  low_bits,   // Low byte register
  input  wire logic        bit9,       // Standard bit 9 source
  input  wire logic        bit8,       // Standard bit 8 source
  input  wire logic [3:0]  ext_nib,    // Extended upper nibble
  input  wire logic        ext_mode,   // Extended timing enable
  output vval_t            value       // Composed value
);
  // Unused standard overflow bits drop out entirely in extended mode
  always_comb begin
    if (ext_mode) begin
      value = {ext_nib, low_bits};
    end else begin
      value = {2'b00, bit9, bit8, low_bits};
    end
  end
endmodule // vtiming_compose

// *** vtiming_regs.sv ***
// Indexed timing registers, vertical value composition, split screen and panning
//
// Summary of operation
// - Standard mode vertical total: low byte, bit9 overflow b5, bit8 overflow b0.
// - Extended mode vertical total upper nibble from extended total register.
// - Line compare: low byte, bit9 max-scan b6, bit8 overflow b4.
// - At line compare the memory address counter restarts at zero.
// - Lines above line compare fetch from the programmed start address.
// - Standard blank start: low byte, bit9 max-scan b5, bit8 overflow b3.
// - Extended blank start upper nibble from extended blank register.
// - Standard sync start: low byte, bit9 overflow b7, bit8 overflow b2.
// - Extended sync start upper nibble from extended sync register.
// - Standard display end: low byte, bit9 overflow b6, bit8 overflow b1.
// - Extended display end upper nibble from extended display register.
// - Line zero is the first active line; starts are line numbers.
// - Byte panning bits 6-5 shift image left zero to three characters.
// - Nine-pixel text: pan codes give 0, 9, 18, 27 pixels.
// - Eight-pixel text and graphics: pan codes give 0, 8, 16, 24.
// - Pixel panning nibble adds a fine shift to the byte shift.
// - Preset row scan bits 4-0 pick first shown line of top row.
// - Preset row register reached at data port while index holds 08h.
// - Vertical total low byte is read and written at the data port while index holds 06h.
`timescale 1ns/10ps
`include "vtiming_cfg.svh"
module vtiming_regs
  import vtiming_pkg::*;
(
  input  wire logic        sys_clk,        // 100 MHz clock
  input  wire logic        rst_n,          // Synchronous reset, active low
  input  wire logic        clk_en,         // Freezes all state while low
  input  wire logic        idx_wr,         // Index port write strobe
  input  wire logic        data_wr,        // Data port write strobe
  input  wire logic        data_rd,        // Data port read strobe
  input  wire logic [7:0]  wdata,          // Write data for either port
  input  wire logic        ext_timing_en,  // Extended timing enable
  input  wire logic        nine_dot_text,  // 9-pixel text character box
  input  wire logic [3:0]  pixel_pan,      // Pixel panning nibble
  input  wire logic        line_start,     // Pulse at start of each scan line
  input  wire logic        frame_start,    // Pulse at line zero of frame
  output logic      [7:0]  rdata,          // Read data, valid two cycles after strobe
  output logic             rvalid,         // Read data valid pulse
  output vval_t            vert_total,     // Composed vertical total
  output vval_t            vert_disp_end,  // Composed display end
  output vval_t            vert_blank_st,  // Composed blanking start
  output vval_t            vert_sync_st,   // Composed sync start
  output logic      [9:0]  line_cmp,       // Composed line compare
  output logic      [9:0]  scan_line,      // Current scan line number
  output logic      [15:0] fetch_base,     // Fetch base address for this line
  output logic      [5:0]  pan_pixels,     // Total left shift in pixels
  output logic      [4:0]  row_preset      // First shown row scan line
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_state_t  st;
    byte_t       index;
    byte_t       rd_buf;
    logic        rvalid;
    byte_t       vtotal;
    byte_t       high_bits;
    byte_t       preset;
    byte_t       max_scan;
    byte_t       vsync;
    byte_t       vdisp;
    byte_t       vblank;
    byte_t       lcmp;
    byte_t       start_hi;
    byte_t       start_lo;
    byte_t       ext_vtotal;
    byte_t       ext_vdisp;
    byte_t       ext_vsync;
    byte_t       ext_vblank;
    logic        ext_sync1;
    logic        ext_sync2;
    logic        nine_sync1;
    logic        nine_sync2;
    logic [3:0]  pan_sync1;
    logic [3:0]  pan_sync2;
    vval_t       vtotal_o;
    vval_t       vdisp_o;
    vval_t       vblank_o;
    vval_t       vsync_o;
    logic [9:0]  lcmp_o;
    logic [9:0]  line;
    logic [15:0] base;
    logic [5:0]  pan;
    logic [4:0]  row;
  } state_t;

  state_t state_reg;
  state_t state_next;

  vval_t vtotal_c;
  vval_t vdisp_c;
  vval_t vblank_c;
  vval_t vsync_c;

  // Read mux of the indexed set; unmapped indices read zero
  function automatic byte_t read_reg(input state_t s, input byte_t idx);
    byte_t r;
    r = `REG_RESET;
    unique case (idx)
      `IDX_VERT_TOTAL:   r = s.vtotal;
      `IDX_HIGH_BITS:    r = s.high_bits;
      `IDX_PRESET_ROW:   r = s.preset & `PR_WRITE_MASK;
      `IDX_MAX_SCAN:     r = s.max_scan;
      `IDX_VSYNC_START:  r = s.vsync;
      `IDX_VDISP_END:    r = s.vdisp;
      `IDX_VBLANK_START: r = s.vblank;
      `IDX_LINE_CMP:     r = s.lcmp;
      `IDX_START_HI:     r = s.start_hi;
      `IDX_START_LO:     r = s.start_lo;
      `IDX_EXT_VTOTAL:   r = s.ext_vtotal;
      `IDX_EXT_VDISP:    r = s.ext_vdisp;
      `IDX_EXT_VSYNC:    r = s.ext_vsync;
      `IDX_EXT_VBLANK:   r = s.ext_vblank;
      default:           r = `REG_RESET;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Value composition
  // ----------------------------------------------------------------
  vtiming_compose u_total (
    .low_bits (state_reg.vtotal),
    .bit9     (state_reg.high_bits[`HB_VTOTAL_B9]),
    .bit8     (state_reg.high_bits[`HB_VTOTAL_B8]),
    .ext_nib  (state_reg.ext_vtotal[3:0]),
    .ext_mode (state_reg.ext_sync2),
    .value    (vtotal_c)
  );
  vtiming_compose u_disp (
    .low_bits (state_reg.vdisp),
    .bit9     (state_reg.high_bits[`HB_VDISP_B9]),
    .bit8     (state_reg.high_bits[`HB_VDISP_B8]),
    .ext_nib  (state_reg.ext_vdisp[3:0]),
    .ext_mode (state_reg.ext_sync2),
    .value    (vdisp_c)
  );
  vtiming_compose u_blank (
    .low_bits (state_reg.vblank),
    .bit9     (state_reg.max_scan[`MS_VBLANK_B9]),
    .bit8     (state_reg.high_bits[`HB_VBLANK_B8]),
    .ext_nib  (state_reg.ext_vblank[3:0]),
    .ext_mode (state_reg.ext_sync2),
    .value    (vblank_c)
  );
  vtiming_compose u_sync (
    .low_bits (state_reg.vsync),
    .bit9     (state_reg.high_bits[`HB_VSYNC_B9]),
    .bit8     (state_reg.high_bits[`HB_VSYNC_B8]),
    .ext_nib  (state_reg.ext_vsync[3:0]),
    .ext_mode (state_reg.ext_sync2),
    .value    (vsync_c)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0] cmp;
    logic [5:0] char_w;
    cmp    = {state_reg.max_scan[`MS_LCMP_B9], state_reg.high_bits[`HB_LCMP_B8], state_reg.lcmp};
    char_w = state_reg.nine_sync2 ? {1'b0, `CHAR_W9} : {1'b0, `CHAR_W8};
    state_next        = state_reg;
    state_next.rvalid = 1'b0;

    // Mode straps come from outside; two stages before use
    state_next.ext_sync1  = ext_timing_en;
    state_next.ext_sync2  = state_reg.ext_sync1;
    state_next.nine_sync1 = nine_dot_text;
    state_next.nine_sync2 = state_reg.nine_sync1;
    state_next.pan_sync1  = pixel_pan;
    state_next.pan_sync2  = state_reg.pan_sync1;

    // Bus sequencing: strobe is taken, then data stored or read
    unique case (state_reg.st)
      ST_IDLE: begin
        if (idx_wr) begin
          state_next.index = wdata;
        end else if (data_wr) begin
          state_next.rd_buf = wdata;
          state_next.st     = ST_WRITE;
        end else if (data_rd) begin
          state_next.st = ST_READ;
        end
      end
      ST_WRITE: begin
        unique case (state_reg.index)
          `IDX_VERT_TOTAL:   state_next.vtotal     = state_reg.rd_buf;
          `IDX_HIGH_BITS:    state_next.high_bits  = state_reg.rd_buf;
          `IDX_PRESET_ROW:   state_next.preset     = state_reg.rd_buf & `PR_WRITE_MASK;
          `IDX_MAX_SCAN:     state_next.max_scan   = state_reg.rd_buf;
          `IDX_VSYNC_START:  state_next.vsync      = state_reg.rd_buf;
          `IDX_VDISP_END:    state_next.vdisp      = state_reg.rd_buf;
          `IDX_VBLANK_START: state_next.vblank     = state_reg.rd_buf;
          `IDX_LINE_CMP:     state_next.lcmp       = state_reg.rd_buf;
          `IDX_START_HI:     state_next.start_hi   = state_reg.rd_buf;
          `IDX_START_LO:     state_next.start_lo   = state_reg.rd_buf;
          `IDX_EXT_VTOTAL:   state_next.ext_vtotal = state_reg.rd_buf & `EXT_NIB_MASK;
          `IDX_EXT_VDISP:    state_next.ext_vdisp  = state_reg.rd_buf & `EXT_NIB_MASK;
          `IDX_EXT_VSYNC:    state_next.ext_vsync  = state_reg.rd_buf & `EXT_NIB_MASK;
          `IDX_EXT_VBLANK:   state_next.ext_vblank = state_reg.rd_buf & `EXT_NIB_MASK;
          default:           state_next.st         = ST_IDLE;
        endcase
        state_next.st = ST_IDLE;
      end
      ST_READ: begin
        state_next.rd_buf = read_reg(state_reg, state_reg.index);
        state_next.rvalid = 1'b1;
        state_next.st     = ST_IDLE;
      end
      default: state_next.st = ST_IDLE;
    endcase

    // Registered composed values
    state_next.vtotal_o = vtotal_c;
    state_next.vdisp_o  = vdisp_c;
    state_next.vblank_o = vblank_c;
    state_next.vsync_o  = vsync_c;
    state_next.lcmp_o   = cmp;

    // Line counter: zero is the first active line
    if (frame_start) begin
      state_next.line = 10'h000;
      state_next.base = {state_reg.start_hi, state_reg.start_lo};
    end else if (line_start) begin
      state_next.line = state_reg.line + 10'h001;
      if (state_reg.line + 10'h001 == cmp) begin
        state_next.base = 16'h0000;
      end
    end

    // Coarse plus fine shift
    state_next.pan = 6'(char_w * {4'h0, state_reg.preset[`PR_PAN_HI:`PR_PAN_LO]})
                   + {2'b00, state_reg.pan_sync2};
    state_next.row = state_reg.preset[`PR_ROW_HI:`PR_ROW_LO];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg    <= '0;
      state_reg.st <= ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign rdata         = state_reg.rd_buf;
  assign rvalid        = state_reg.rvalid;
  assign vert_total    = state_reg.vtotal_o;
  assign vert_disp_end = state_reg.vdisp_o;
  assign vert_blank_st = state_reg.vblank_o;
  assign vert_sync_st  = state_reg.vsync_o;
  assign line_cmp      = state_reg.lcmp_o;
  assign scan_line     = state_reg.line;
  assign fetch_base    = state_reg.base;
  assign pan_pixels    = state_reg.pan;
  assign row_preset    = state_reg.row;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_std_total: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !state_reg.ext_sync2 |=> vert_total[11:10] == 2'b00)
    else $error("standard vertical total exceeds 10 bits");
  a_ext_total: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && state_reg.ext_sync2 |=> vert_total[11:8] == $past(state_reg.ext_vtotal[3:0]))
    else $error("extended vertical total nibble wrong");
  a_lcmp_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> line_cmp == {$past(state_reg.max_scan[6]), $past(state_reg.high_bits[4]), $past(state_reg.lcmp)})
    else $error("line compare composition wrong");
  a_split_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !frame_start && line_start &&
    (state_reg.line + 10'h001 == {state_reg.max_scan[6], state_reg.high_bits[4], state_reg.lcmp}) |=> fetch_base == 16'h0000)
    else $error("fetch base not zero at line compare");
  a_frame_base: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && frame_start |=> fetch_base == $past({state_reg.start_hi, state_reg.start_lo}))
    else $error("frame does not start at start address");
  a_blank_std: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !state_reg.ext_sync2 |=> vert_blank_st[9] == $past(state_reg.max_scan[5]))
    else $error("blank start bit 9 wrong");
  a_sync_std: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !state_reg.ext_sync2 |=> vert_sync_st[9:8] == {$past(state_reg.high_bits[7]), $past(state_reg.high_bits[2])})
    else $error("sync start bits wrong");
  a_pan_nine: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && state_reg.nine_sync2 && state_reg.preset[6:5] == 2'b11 && state_reg.pan_sync2 == 4'h0
    |=> pan_pixels == 6'h1B)
    else $error("nine pixel byte pan wrong");
  a_pan_eight: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !state_reg.nine_sync2 && state_reg.preset[6:5] == 2'b10 && state_reg.pan_sync2 == 4'h0
    |=> pan_pixels == 6'h10)
    else $error("eight pixel byte pan wrong");
  a_resv_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rvalid && $past(state_reg.index, 2) == 8'h08 |-> rdata[7] == 1'b0)
    else $error("reserved preset bit reads one");

endmodule // vtiming_regs

// *** scan_source.sv ***
// Behavioural scan timing source standing in for the display side
`timescale 1ns/10ps
module scan_source #(
  parameter int LINES = 8,  // Lines issued per frame
  parameter int GAP   = 4   // Idle cycles between line pulses
) (
  input  wire logic sys_clk,      // System clock
  input  wire logic run,          // Start one frame when high
  output logic      frame_start,  // Line zero pulse
  output logic      line_start    // Next line pulse
);
  initial begin
    frame_start = 1'b0;
    line_start  = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (run) begin
        // Frame pulse always marks the first active line
        #1 frame_start = 1'b1;
        @(posedge sys_clk);
        #1 frame_start = 1'b0;
        for (int i = 1; i < LINES; i++) begin
          repeat (GAP) @(posedge sys_clk);
          #1 line_start = 1'b1;
          @(posedge sys_clk);
          #1 line_start = 1'b0;
        end
      end
    end
  end
endmodule // scan_source

// *** vtiming_regs_tb.sv ***
// Self-checking testbench for the vertical timing register block
`timescale 1ns/10ps
`include "vtiming_cfg.svh"
module vtiming_regs_tb
  import vtiming_pkg::*;
;
  logic        sys_clk, rst_n, clk_en, idx_wr, data_wr, data_rd, rvalid, run;
  logic        ext_timing_en, nine_dot_text, line_start, frame_start;
  logic [7:0]  wdata, rdata, rd_val, ovf, ms;
  logic [3:0]  pixel_pan;
  logic [1:0]  c;
  vval_t       vert_total, vert_disp_end, vert_blank_st, vert_sync_st;
  logic [9:0]  line_cmp, scan_line;
  logic [15:0] fetch_base;
  logic [5:0]  pan_pixels;
  logic [4:0]  row_preset;
  int          err_total, n_tests, cycles, k, pe;
  byte_t       lv [5];
  byte_t       lo0 [5] = '{8'hC3, 8'h96, 8'h4B, 8'h2D, 8'h71};
  byte_t       li [5]  = '{`IDX_VERT_TOTAL, `IDX_VDISP_END, `IDX_VBLANK_START, `IDX_VSYNC_START, `IDX_LINE_CMP};
  byte_t       xv [4]  = '{8'hA3, 8'hB5, 8'hD9, 8'hEC};
  byte_t       xi [4]  = '{`IDX_EXT_VTOTAL, `IDX_EXT_VDISP, `IDX_EXT_VBLANK, `IDX_EXT_VSYNC};

  vtiming_regs dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .idx_wr(idx_wr), .data_wr(data_wr),
    .data_rd(data_rd), .wdata(wdata), .ext_timing_en(ext_timing_en), .nine_dot_text(nine_dot_text),
    .pixel_pan(pixel_pan), .line_start(line_start), .frame_start(frame_start), .rdata(rdata), .rvalid(rvalid),
    .vert_total(vert_total), .vert_disp_end(vert_disp_end), .vert_blank_st(vert_blank_st),
    .vert_sync_st(vert_sync_st), .line_cmp(line_cmp), .scan_line(scan_line), .fetch_base(fetch_base),
    .pan_pixels(pan_pixels), .row_preset(row_preset));

  scan_source #(.LINES(8), .GAP(4)) src_u (.sys_clk(sys_clk), .run(run), .frame_start(frame_start),
    .line_start(line_start));

  // ----------------------------------------------------------------
  // Clock, timeout and checking helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Whole run is roughly 400 cycles; generous ceiling
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic settle();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr_idx(input byte_t idx);
    @(posedge sys_clk);
    #1 idx_wr = 1'b1;
    wdata = idx;
    @(posedge sys_clk);
    #1 idx_wr = 1'b0;
  endtask

  // Data strobes leave an idle cycle behind them for the busy state
  task automatic wr_reg(input byte_t idx, input byte_t d);
    wr_idx(idx);
    @(posedge sys_clk);
    #1 data_wr = 1'b1;
    wdata = d;
    @(posedge sys_clk);
    #1 data_wr = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd_reg(input byte_t idx, output logic [7:0] d);
    wr_idx(idx);
    @(posedge sys_clk);
    #1 data_rd = 1'b1;
    @(posedge sys_clk);
    #1 data_rd = 1'b0;
    for (int n = 0; n < 4 && rvalid !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk({15'h0000, rvalid}, 16'h0001, "read answer");
    d = rdata;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check_vals(input logic ext);
    chk(vert_total, ext ? {xv[0][3:0], lv[0]} : {ovf[5], ovf[0], lv[0]}, "total");
    chk(vert_disp_end, ext ? {xv[1][3:0], lv[1]} : {ovf[6], ovf[1], lv[1]}, "disp end");
    chk(vert_blank_st, ext ? {xv[2][3:0], lv[2]} : {ms[5], ovf[3], lv[2]}, "blank");
    chk(vert_sync_st, ext ? {xv[3][3:0], lv[3]} : {ovf[7], ovf[2], lv[3]}, "sync");
    chk(line_cmp, {ms[6], ovf[4], lv[4]}, "line compare");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, idx_wr, data_wr, data_rd, ext_timing_en, nine_dot_text, run} = 7'h00;
    clk_en = 1'b1;
    wdata = 8'h00;
    pixel_pan = 4'h0;
    {err_total, n_tests, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk(vert_total, 16'h0000, "reset total");
    chk(fetch_base, 16'h0000, "reset fetch");
    rd_reg(`IDX_PRESET_ROW, rd_val);
    chk(rd_val, 16'h0000, "preset reset");
    wr_reg(`IDX_PRESET_ROW, 8'hFF);
    rd_reg(`IDX_PRESET_ROW, rd_val);
    chk(rd_val, 16'h007F, "reserved bit");
    rd_reg(8'h3F, rd_val);
    chk(rd_val, 16'h0000, "unmapped index");
    // A write attempted while frozen must leave the register untouched
    clk_en = 1'b0;
    wr_reg(`IDX_PRESET_ROW, 8'h15);
    clk_en = 1'b1;
    rd_reg(`IDX_PRESET_ROW, rd_val);
    chk(rd_val, 16'h007F, "frozen write");
    // Byte pan codes in both box widths, with a fine pan on top
    for (int t = 0; t < 8; t++) begin
      c = 2'(t);
      nine_dot_text = (t > 3);
      pixel_pan = 4'(15 - 2 * t);
      wr_reg(`IDX_PRESET_ROW, {1'b1, c, 3'b101, c});
      settle();
      pe = c * ((t > 3) ? 9 : 8) + pixel_pan;
      chk(pan_pixels, 16'(pe), "pan");
      chk(row_preset, {3'b101, c}, "row preset");
    end
    // Extended nibbles written first must not leak into standard values
    for (int x = 0; x < 4; x++) wr_reg(xi[x], xv[x]);
    for (int s = 0; s < 2; s++) begin
      ovf = s ? 8'h5A : 8'hA5;
      ms = s ? 8'h9F : 8'h60;
      wr_reg(`IDX_HIGH_BITS, ovf);
      wr_reg(`IDX_MAX_SCAN, ms);
      for (int x = 0; x < 5; x++) begin
        lv[x] = s ? ~lo0[x] : lo0[x];
        wr_reg(li[x], lv[x]);
      end
      settle();
      check_vals(1'b0);
      rd_reg(`IDX_VERT_TOTAL, rd_val);
      chk(rd_val, lv[0], "total readback");
      rd_reg(`IDX_HIGH_BITS, rd_val);
      chk(rd_val, ovf, "high bits readback");
    end
    ext_timing_en = 1'b1;
    settle();
    check_vals(1'b1);
    ext_timing_en = 1'b0;
    // Split screen: eight active lines, compare at line three
    wr_reg(`IDX_VERT_TOTAL, 8'h06);
    wr_reg(`IDX_VDISP_END, 8'h07);
    wr_reg(`IDX_HIGH_BITS, 8'h00);
    wr_reg(`IDX_MAX_SCAN, 8'h00);
    wr_reg(`IDX_LINE_CMP, 8'h03);
    wr_reg(`IDX_START_HI, 8'h12);
    wr_reg(`IDX_START_LO, 8'h34);
    wr_reg(`IDX_PRESET_ROW, 8'h00);
    settle();
    run = 1'b1;
    for (int ln = 0; ln < 8; ln++) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        #2;
        k++;
      end while (frame_start !== 1'b1 && line_start !== 1'b1 && k < 20);
      run = 1'b0;
      @(posedge sys_clk);
      #1;
      chk(scan_line, 16'(ln), "scan line");
      chk(fetch_base, (ln >= 3) ? 16'h0000 : 16'h1234, "fetch base");
    end
    stop_test();
  end
endmodule // vtiming_regs_tb
